// file: common/config_pin_pkg.sv
package config_pin_pkg;

	// ==========================================================
	// Pin synchroniser layout
	localparam int SYNC_W = 46;
	localparam int S_LANE = 0;
	localparam int S_TCK = 32;
	localparam int S_TMS = 33;
	localparam int S_TDI = 34;
	localparam int S_RECONF = 35;
	localparam int S_CSI = 36;
	localparam int S_SSN = 37;
	localparam int S_CCLK = 38;
	localparam int S_DONE = 39;
	localparam int S_WIDTH = 40;
	localparam int S_IMAGE = 43;
	localparam int S_TESTN = 45;
	// Pulled-up pins read one until first sampled
	localparam logic [SYNC_W-1:0] SYNC_INIT = 46'h27EE_0000_0000;

	// ==========================================================
	// Test access port
	localparam int IR_LEN = 4;
	localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h1;
	localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
	localparam int DR_W = 32;

	// ==========================================================
	// Loader
	localparam int WORD_W = 32;
	localparam int BUF_DEPTH = 2;
	localparam int CNT_W = 6;
	localparam logic [31:0] SPI_READ_CMD = 32'h0300_0000;
	localparam logic [CNT_W-1:0] CMD_BITS = 6'h20;
	localparam logic [CNT_W-1:0] WORD_BITS = 6'h20;
	localparam logic [2:0] WIDTH_X1 = 3'h7;
	localparam logic [2:0] WIDTH_X2 = 3'h6;
	localparam logic [2:0] WIDTH_X4 = 3'h5;
	localparam logic [2:0] WIDTH_X8 = 3'h4;
	localparam logic [2:0] WIDTH_X16 = 3'h3;
	localparam logic [2:0] WIDTH_X32 = 3'h2;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS = 32;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
		SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [3:0] SCLK_LAST = 4'(SCLK_HALF_CYC - 1);

	typedef enum {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} tap_state_t;

	typedef enum {CFG_IDLE, CFG_LOAD, CFG_RELEASE, CFG_USER, CFG_ERROR} cfg_state_t;

	typedef struct packed {
		logic active;
		logic [2:0] width;
		logic [1:0] image;
	} straps_t;

endpackage

// file: design/cfg_word_buffer.sv
`timescale 1ns/10ps
module cfg_word_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [DEPTH-1:0] next_vld;
	logic placed;

	// ==========================================================
	// Head at entry 0, shift down on pop
	assign in_ready_o = ~vld[DEPTH-1];
	assign out_data_o = mem[0];
	assign out_valid_o = vld[0];

	always_comb begin
		next_mem = mem;
		next_vld = vld;
		placed = 1'b0;
		if (vld[0] && out_ready_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_mem[i] = mem[i+1];
				next_vld[i] = vld[i+1];
			end
			next_vld[DEPTH-1] = 1'b0;
		end
		if (in_valid_i && in_ready_o) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !next_vld[i]) begin
					next_mem[i] = in_data_i;
					next_vld[i] = 1'b1;
					placed = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vld <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			vld <= next_vld;
			mem <= next_mem;
		end
	end
endmodule

// file: design/config_pin_control.sv
`timescale 1ns/10ps
//
// Function
// - Done pin is open drain, released only after loading completes
// - User mode waits until the done pin actually reads high
// - Fresh load starts on request pin rising edge; user logic not reset
// - Test mode select and test data sampled on test clock rise
// - Test data output changes only after test clock fall
// - Undriven test mode select reads as one
// - Test data goes to instruction or data register per state
// - Shifted bit appears after register-length clocks
// - Test data output undriven when not shifting
// - Three-bit bus width select sets data width in passive mode, defaults high
// - Image select chooses image when multi-image enabled
// - Config clock input when passive, output only while loading in active mode
// - Lane 0 and lane 1 swap serial roles; lanes to 31 parallel
// - Loading accepted only while chip select in is high
// - Chip select out enables next device in the chain
// - Error pin low on id mismatch, CRC fail or update fail
// - Slave select sampled at request rise picks passive or active
// - Slave select is input at sampling, output only while loading in active mode
// - Dual-purpose pins released after configuration
module config_pin_control #(
	parameter logic [31:0] IDCODE = 32'h1000_0001 // Arbitrary value
) (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic CONFIG_DONE_I,
	output logic CONFIG_DONE_O,
	output logic CONFIG_DONE_OE_O,
	input wire logic RECONFIG_REQUEST_N_I,
	input wire logic TCK_I,
	input wire logic TMS_I,
	input wire logic TDI_I,
	output logic TDO_O,
	output logic TDO_OE_O,
	input wire logic [2:0] BUS_WIDTH_SELECT_I,
	input wire logic [1:0] IMAGE_SELECT_I,
	input wire logic MULTI_IMAGE_EN_I,
	input wire logic CONFIG_CLOCK_I,
	output logic CONFIG_CLOCK_O,
	output logic CONFIG_CLOCK_OE_O,
	input wire logic [31:0] CONFIG_DATA_LANE_I,
	output logic [1:0] CONFIG_DATA_LANE_O,
	output logic [1:0] CONFIG_DATA_LANE_OE_O,
	input wire logic CHIP_SELECT_IN_I,
	output logic CHIP_SELECT_OUT_O,
	output logic CONFIG_ERROR_N_O,
	input wire logic SPI_SELECT_N_I,
	output logic SPI_SELECT_N_O,
	output logic SPI_SELECT_N_OE_O,
	input wire logic TEST_ENABLE_N_I,
	output logic TEST_MODE_O,
	input wire logic LOAD_DONE_I,
	input wire logic ID_MISMATCH_I,
	input wire logic CRC_FAIL_I,
	input wire logic UPDATE_FAIL_I,
	output logic [31:0] STREAM_DATA_O,
	output logic STREAM_VALID_O,
	input wire logic STREAM_READY_I,
	output config_pin_pkg::straps_t STRAPS_O,
	output logic USER_MODE_O,
	output logic DUAL_PIN_RELEASE_O
);
	import config_pin_pkg::*;

	// ==========================================================
	// Pin synchronisers, change accepted when stages 2 and 3 agree
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] s1;
	logic [SYNC_W-1:0] s2;
	logic [SYNC_W-1:0] s3;
	logic [SYNC_W-1:0] pin;
	logic [SYNC_W-1:0] pin_d;

	assign raw = {TEST_ENABLE_N_I, IMAGE_SELECT_I, BUS_WIDTH_SELECT_I, CONFIG_DONE_I,
		CONFIG_CLOCK_I, SPI_SELECT_N_I, CHIP_SELECT_IN_I, RECONFIG_REQUEST_N_I,
		TDI_I, TMS_I, TCK_I, CONFIG_DATA_LANE_I};

	generate
		for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
			always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					s1[g] <= SYNC_INIT[g];
					s2[g] <= SYNC_INIT[g];
					s3[g] <= SYNC_INIT[g];
					pin[g] <= SYNC_INIT[g];
					pin_d[g] <= SYNC_INIT[g];
				end else begin
					s1[g] <= raw[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					pin[g] <= (s2[g] == s3[g]) ? s3[g] : pin[g];
					pin_d[g] <= pin[g];
				end
			end
		end
	endgenerate

	logic tck_rise;
	logic tck_fall;
	logic reconf_rise;
	logic cclk_rise;
	assign tck_rise = pin[S_TCK] & ~pin_d[S_TCK];
	assign tck_fall = ~pin[S_TCK] & pin_d[S_TCK];
	assign reconf_rise = pin[S_RECONF] & ~pin_d[S_RECONF];
	assign cclk_rise = pin[S_CCLK] & ~pin_d[S_CCLK];

	// ==========================================================
	// Configuration sequencer
	cfg_state_t state;
	cfg_state_t next_state;
	straps_t straps;
	straps_t next_straps;
	logic fail;
	logic loading;
	assign fail = ID_MISMATCH_I | CRC_FAIL_I | UPDATE_FAIL_I;
	assign loading = (state == CFG_LOAD) && pin[S_CSI];

	always_comb begin
		next_state = state;
		next_straps = straps;
		if (reconf_rise && pin[S_CSI]) begin
			next_state = CFG_LOAD;
			next_straps.active = pin[S_SSN];
			next_straps.width = pin[S_WIDTH+:3];
			next_straps.image = MULTI_IMAGE_EN_I ? pin[S_IMAGE+:2] : 2'h0;
		end else begin
			unique case (state)
				CFG_IDLE: next_state = CFG_IDLE;
				CFG_LOAD: begin
					if (fail) begin
						next_state = CFG_ERROR;
					end else if (LOAD_DONE_I && pin[S_CSI]) begin
						next_state = CFG_RELEASE;
					end
				end
				CFG_RELEASE: begin
					if (fail) begin
						next_state = CFG_ERROR;
					end else if (pin[S_DONE]) begin
						next_state = CFG_USER;
					end
				end
				CFG_USER: next_state = CFG_USER;
				CFG_ERROR: next_state = CFG_ERROR;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state <= CFG_IDLE;
			straps <= '{active: 1'b1, width: WIDTH_X1, image: 2'h0};
		end else begin
			state <= next_state;
			straps <= next_straps;
		end
	end

	// ==========================================================
	// Serial and parallel loader
	logic [3:0] div;
	logic [3:0] next_div;
	logic sclk;
	logic next_sclk;
	logic [31:0] cmd_sr;
	logic [31:0] next_cmd_sr;
	logic [CNT_W-1:0] cmd_cnt;
	logic [CNT_W-1:0] next_cmd_cnt;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_word;
	logic [CNT_W-1:0] bits;
	logic [CNT_W-1:0] next_bits;
	logic word_valid;
	logic next_word_valid;
	logic buf_ready;
	logic [CNT_W-1:0] bpe;
	logic take;
	logic [WORD_W-1:0] din;

	always_comb begin
		unique case (straps.width)
			WIDTH_X2: bpe = 6'h02;
			WIDTH_X4: bpe = 6'h04;
			WIDTH_X8: bpe = 6'h08;
			WIDTH_X16: bpe = 6'h10;
			WIDTH_X32: bpe = 6'h20;
			default: bpe = 6'h01;
		endcase
		if (straps.active) begin
			bpe = 6'h01;
		end
	end

	always_comb begin
		next_div = div;
		next_sclk = sclk;
		next_cmd_sr = cmd_sr;
		next_cmd_cnt = cmd_cnt;
		next_word = word;
		next_bits = bits;
		next_word_valid = word_valid && !buf_ready;
		take = 1'b0;
		din = '0;
		if (state != CFG_LOAD || (reconf_rise && pin[S_CSI])) begin
			next_sclk = 1'b1;
			next_div = '0;
			next_cmd_sr = SPI_READ_CMD;
			next_cmd_cnt = '0;
			next_bits = '0;
		end else if (loading && straps.active) begin
			next_div = (div == SCLK_LAST) ? 4'h0 : div + 4'h1;
			if (div == SCLK_LAST && !next_word_valid) begin
				next_sclk = ~sclk;
				if (!sclk) begin
					if (cmd_cnt != CMD_BITS) begin
						next_cmd_cnt = cmd_cnt + 6'h01;
					end else begin
						take = 1'b1;
						din = {31'h0, pin[S_LANE+1]};
					end
				end else if (cmd_cnt != 6'h00) begin
					next_cmd_sr = {cmd_sr[30:0], 1'b0};
				end
			end
		end else if (loading && cclk_rise) begin
			take = 1'b1;
			din = pin[S_LANE+:WORD_W] & ((32'h1 << bpe) - 32'h1);
		end
		if (take) begin
			next_word = (word << bpe) | din;
			next_bits = bits + bpe;
			if (next_bits == WORD_BITS) begin
				next_bits = '0;
				next_word_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			div <= '0;
			sclk <= 1'b1;
			cmd_sr <= SPI_READ_CMD;
			cmd_cnt <= '0;
			word <= '0;
			bits <= '0;
			word_valid <= 1'b0;
		end else begin
			div <= next_div;
			sclk <= next_sclk;
			cmd_sr <= next_cmd_sr;
			cmd_cnt <= next_cmd_cnt;
			word <= next_word;
			bits <= next_bits;
			word_valid <= next_word_valid;
		end
	end

	cfg_word_buffer #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(MCLK_I),
		.reset_n_i(RESET_N_I),
		.in_data_i(word),
		.in_valid_i(word_valid),
		.in_ready_o(buf_ready),
		.out_data_o(STREAM_DATA_O),
		.out_valid_o(STREAM_VALID_O),
		.out_ready_i(STREAM_READY_I)
	);

	// ==========================================================
	// Test access port
	tap_state_t tap;
	tap_state_t next_tap;
	logic [IR_LEN-1:0] ir;
	logic [IR_LEN-1:0] next_ir;
	logic [IR_LEN-1:0] ir_sr;
	logic [IR_LEN-1:0] next_ir_sr;
	logic [DR_W-1:0] dr_sr;
	logic [DR_W-1:0] next_dr_sr;
	logic tdo;
	logic next_tdo;
	logic tdo_oe;
	logic next_tdo_oe;
	logic tms;
	logic tdi;
	assign tms = pin[S_TMS];
	assign tdi = pin[S_TDI];

	always_comb begin
		next_tap = tap;
		next_ir = ir;
		next_ir_sr = ir_sr;
		next_dr_sr = dr_sr;
		next_tdo = tdo;
		next_tdo_oe = tdo_oe;
		if (tck_rise) begin
			unique case (tap)
				TLR: next_tap = tms ? TLR : RTI;
				RTI: next_tap = tms ? SEL_DR : RTI;
				SEL_DR: next_tap = tms ? SEL_IR : CAP_DR;
				CAP_DR: next_tap = tms ? EX1_DR : SH_DR;
				SH_DR: next_tap = tms ? EX1_DR : SH_DR;
				EX1_DR: next_tap = tms ? UPD_DR : PA_DR;
				PA_DR: next_tap = tms ? EX2_DR : PA_DR;
				EX2_DR: next_tap = tms ? UPD_DR : SH_DR;
				UPD_DR: next_tap = tms ? SEL_DR : RTI;
				SEL_IR: next_tap = tms ? TLR : CAP_IR;
				CAP_IR: next_tap = tms ? EX1_IR : SH_IR;
				SH_IR: next_tap = tms ? EX1_IR : SH_IR;
				EX1_IR: next_tap = tms ? UPD_IR : PA_IR;
				PA_IR: next_tap = tms ? EX2_IR : PA_IR;
				EX2_IR: next_tap = tms ? UPD_IR : SH_IR;
				UPD_IR: next_tap = tms ? SEL_DR : RTI;
			endcase
			unique case (tap)
				TLR: next_ir = IR_IDCODE;
				CAP_IR: next_ir_sr = IR_CAPTURE;
				SH_IR: next_ir_sr = {tdi, ir_sr[IR_LEN-1:1]};
				UPD_IR: next_ir = ir_sr;
				CAP_DR: next_dr_sr = (ir == IR_IDCODE) ? IDCODE : '0;
				SH_DR: next_dr_sr = (ir == IR_IDCODE) ? {tdi, dr_sr[DR_W-1:1]} :
					{dr_sr[DR_W-1:1], tdi};
				default: next_ir = ir;
			endcase
		end
		if (tck_fall) begin
			next_tdo_oe = (tap == SH_DR) || (tap == SH_IR);
			next_tdo = (tap == SH_IR) ? ir_sr[0] : dr_sr[0];
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tap <= TLR;
			ir <= IR_IDCODE;
			ir_sr <= '0;
			dr_sr <= '0;
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tap <= next_tap;
			ir <= next_ir;
			ir_sr <= next_ir_sr;
			dr_sr <= next_dr_sr;
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// ==========================================================
	// Registered pin drivers
	logic in_user;
	logic pas_load;
	logic act_load;
	assign in_user = (next_state == CFG_USER);
	assign pas_load = (next_state == CFG_LOAD) && !next_straps.active;
	assign act_load = (next_state == CFG_LOAD) && next_straps.active;

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			CONFIG_DONE_OE_O <= 1'b1;
			CONFIG_ERROR_N_O <= 1'b1;
			CHIP_SELECT_OUT_O <= 1'b0;
			USER_MODE_O <= 1'b0;
			DUAL_PIN_RELEASE_O <= 1'b0;
			CONFIG_CLOCK_O <= 1'b1;
			CONFIG_CLOCK_OE_O <= 1'b0;
			CONFIG_DATA_LANE_O <= 2'h0;
			CONFIG_DATA_LANE_OE_O <= 2'h0;
			SPI_SELECT_N_OE_O <= 1'b0;
			TEST_MODE_O <= 1'b0;
			STRAPS_O <= '{active: 1'b1, width: WIDTH_X1, image: 2'h0};
		end else begin
			CONFIG_DONE_OE_O <= !(in_user || next_state == CFG_RELEASE);
			CONFIG_ERROR_N_O <= (next_state != CFG_ERROR);
			CHIP_SELECT_OUT_O <= in_user;
			USER_MODE_O <= in_user;
			DUAL_PIN_RELEASE_O <= in_user;
			CONFIG_CLOCK_O <= next_sclk;
			CONFIG_CLOCK_OE_O <= act_load;
			CONFIG_DATA_LANE_O <= {pin[S_LANE], next_cmd_sr[31]};
			CONFIG_DATA_LANE_OE_O <= {pas_load, act_load};
			SPI_SELECT_N_OE_O <= act_load && pin[S_RECONF];
			TEST_MODE_O <= !pin[S_TESTN];
			STRAPS_O <= next_straps;
		end
	end

	assign CONFIG_DONE_O = 1'b0;
	assign SPI_SELECT_N_O = 1'b0;
	assign TDO_O = tdo;
	assign TDO_OE_O = tdo_oe;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);

	property p_done_release;
		!CONFIG_DONE_OE_O |-> (state == CFG_RELEASE || state == CFG_USER);
	endproperty
	a_done_release: assert property (p_done_release) else $error("done released early");

	property p_user_gate;
		$rose(USER_MODE_O) |-> $past(pin[S_DONE]);
	endproperty
	a_user_gate: assert property (p_user_gate) else $error("user mode with done low");

	property p_restart;
		reconf_rise && pin[S_CSI] |=> state == CFG_LOAD ##1 !CONFIG_ERROR_N_O || USER_MODE_O == 1'b0;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart on request");

	property p_tdo_fall;
		$changed(tdo) || $changed(tdo_oe) |-> $past(tck_fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");

	property p_tdo_idle;
		tck_fall && !(tap == SH_DR || tap == SH_IR) |=> !TDO_OE_O;
	endproperty
	a_tdo_idle: assert property (p_tdo_idle) else $error("tdo driven idle");

	property p_csi_gate;
		state == CFG_IDLE && !pin[S_CSI] |=> state == CFG_IDLE;
	endproperty
	a_csi_gate: assert property (p_csi_gate) else $error("load without select");

	property p_error;
		state == CFG_LOAD && fail && !reconf_rise |=> !CONFIG_ERROR_N_O;
	endproperty
	a_error: assert property (p_error) else $error("error pin not low");

	property p_mode;
		reconf_rise && pin[S_CSI] |=> straps.active == $past(pin[S_SSN]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode strap wrong");

	property p_cso;
		CHIP_SELECT_OUT_O |-> state == CFG_USER;
	endproperty
	a_cso: assert property (p_cso) else $error("chain select early");

	property p_cclk_dir;
		CONFIG_CLOCK_OE_O |-> state == CFG_LOAD && straps.active;
	endproperty
	a_cclk_dir: assert property (p_cclk_dir) else $error("clock driven passive");
endmodule

// file: tb/cfg_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host side: test controller and passive serial loader
module cfg_host_model (
	input wire logic tdo_i,
	input wire logic tdo_oe_i,
	output logic tck_o,
	output wire logic tms_o,
	output wire logic tdi_o,
	output logic cclk_o,
	output logic [31:0] lane_o
);
	logic tms_en;
	logic tms_v;
	logic tdi_en;
	logic tdi_v;

	// Weak pull-ups on released test inputs
	assign tms_o = tms_en ? tms_v : 1'b1;
	assign tdi_o = tdi_en ? tdi_v : 1'b1;

	initial begin
		tck_o = 1'b0;
		tms_en = 1'b0;
		tms_v = 1'b0;
		tdi_en = 1'b0;
		tdi_v = 1'b0;
		cclk_o = 1'b1;
		lane_o = 32'h0000_0000;
	end

	// ==========================================================
	// Test clock frames; inputs change just after the fall
	task automatic tap_reset();
		tms_en = 1'b0;
		tdi_en = 1'b0;
		repeat (6) begin
			#40 tck_o = 1'b1;
			#40 tck_o = 1'b0;
		end
	endtask

	task automatic jtag_bit(input logic tms, input logic tdi, output logic tdo, output logic oe);
		tms_en = 1'b1;
		tdi_en = 1'b1;
		tms_v = tms;
		tdi_v = tdi;
		#40 tck_o = 1'b1;
		#39 tdo = tdo_i;
		oe = tdo_oe_i;
		#1 tck_o = 1'b0;
	endtask

	// ==========================================================
	// Passive serial word, first bit most significant
	task automatic send_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			cclk_o = 1'b0;
			lane_o[0] = w[i];
			#40 cclk_o = 1'b1;
			#20;
			if (i == 0) lane_o = ~lane_o;
			#20;
		end
	endtask
endmodule

// file: tb/config_pin_control_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
	$display("Error %s expected %0h seen %0h", nm, exp, got); end end
module config_pin_control_tb;
	import config_pin_pkg::*;
	localparam logic [31:0] ID_TB = 32'h1357_2469; // Arbitrary value
	logic mclk, reset_n, req_n, ss_v, csi, multi_en, test_n, ready, done_hold;
	logic load_done, id_mis, crc_fail, upd_fail;
	logic [2:0] width;
	logic [1:0] image;
	logic done_o, done_oe, tdo, tdo_oe, cclk_o, cclk_oe, chip_select_out, error_n, ss_o, ss_oe;
	logic test_mode, stream_valid, user, dual;
	logic [1:0] lane_o, lane_oe;
	logic [31:0] stream_data, host_lane;
	straps_t straps;
	wire logic tck, tms, tdi, host_cclk;
	wire logic done_pin, cclk_pin, ss_pin;
	wire logic [31:0] lane_pin;
	int failures = 0;
	int checks_done = 0;
	int seed = 32'heb16;
	logic [31:0] d, w0, w1, cmd;
	logic [7:0] pat;
	logic oe;

	// ==========================================================
	// Pin resolution with pull-ups
	assign done_pin = done_oe ? done_o : ~done_hold;
	assign cclk_pin = cclk_oe ? cclk_o : host_cclk;
	assign ss_pin = ss_oe ? ss_o : ss_v;
	assign lane_pin = {host_lane[31:2], lane_oe[1] ? lane_o[1] : host_lane[1],
		lane_oe[0] ? lane_o[0] : host_lane[0]};

	config_pin_control #(.IDCODE(ID_TB)) config_pin_control_i (.MCLK_I(mclk), .RESET_N_I(reset_n),
		.CONFIG_DONE_I(done_pin), .CONFIG_DONE_O(done_o), .CONFIG_DONE_OE_O(done_oe),
		.RECONFIG_REQUEST_N_I(req_n), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
		.TDO_OE_O(tdo_oe), .BUS_WIDTH_SELECT_I(width), .IMAGE_SELECT_I(image),
		.MULTI_IMAGE_EN_I(multi_en), .CONFIG_CLOCK_I(cclk_pin), .CONFIG_CLOCK_O(cclk_o),
		.CONFIG_CLOCK_OE_O(cclk_oe), .CONFIG_DATA_LANE_I(lane_pin), .CONFIG_DATA_LANE_O(lane_o),
		.CONFIG_DATA_LANE_OE_O(lane_oe), .CHIP_SELECT_IN_I(csi), .CHIP_SELECT_OUT_O(chip_select_out),
		.CONFIG_ERROR_N_O(error_n), .SPI_SELECT_N_I(ss_pin), .SPI_SELECT_N_O(ss_o),
		.SPI_SELECT_N_OE_O(ss_oe), .TEST_ENABLE_N_I(test_n), .TEST_MODE_O(test_mode),
		.LOAD_DONE_I(load_done), .ID_MISMATCH_I(id_mis), .CRC_FAIL_I(crc_fail),
		.UPDATE_FAIL_I(upd_fail), .STREAM_DATA_O(stream_data), .STREAM_VALID_O(stream_valid),
		.STREAM_READY_I(ready), .STRAPS_O(straps), .USER_MODE_O(user), .DUAL_PIN_RELEASE_O(dual));

	cfg_host_model cfg_host_model_i (.tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi), .cclk_o(host_cclk), .lane_o(host_lane));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ==========================================================
	// Tasks
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic req(input logic s);
		@(negedge mclk);
		ss_v = s;
		req_n = 1'b0;
		step(10);
		req_n = 1'b1;
	endtask

	task automatic get_word(input logic [31:0] exp);
		for (int i = 0; i < 200 && stream_valid !== 1'b1; i++) @(negedge mclk);
		`CHK("stream_valid", 1'b1, stream_valid)
		`CHK("stream_data", exp, stream_data)
		ready = 1'b1;
		step(1);
		ready = 1'b0;
	endtask

	task automatic jmove(input logic [7:0] seq, input int n, output logic last_oe);
		logic t;
		for (int i = 0; i < n; i++) cfg_host_model_i.jtag_bit(seq[i], 1'b1, t, last_oe);
	endtask

	task automatic jshift(input int n, input logic [31:0] din, output logic [31:0] dout,
		output logic oe_all);
		logic o;
		oe_all = 1'b1;
		dout = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			cfg_host_model_i.jtag_bit(i == n - 1, din[i], dout[i], o);
			oe_all = oe_all & o;
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#300000;
		failures++;
		print_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{reset_n, req_n, ss_v, csi, multi_en, test_n, ready, done_hold} = 8'h7C;
		{load_done, id_mis, crc_fail, upd_fail} = 4'h0;
		width = WIDTH_X1;
		image = 2'h0;
		step(20);
		reset_n = 1'b1;
		step(8);
		`CHK("done_oe", 1'b1, done_oe)
		`CHK("error_n", 1'b1, error_n)
		`CHK("cso", 1'b0, chip_select_out)
		`CHK("test_mode", 1'b0, test_mode)
		test_n = 1'b0;
		step(8);
		`CHK("test_mode", 1'b1, test_mode)
		test_n = 1'b1;
		csi = 1'b0;
		req(1'b0);
		step(10);
		`CHK("straps_idle", {1'b1, WIDTH_X1, 2'h0}, straps)
		`CHK("error_idle", 1'b1, error_n)
		csi = 1'b1;
		for (int k = 0; k < 6; k++) begin
			{width, image, multi_en} = 6'($random(seed));
			req(1'b0);
			step(10);
			`CHK("straps", {1'b0, width, multi_en ? image : 2'h0}, straps)
		end
		width = WIDTH_X1;
		req(1'b0);
		step(10);
		`CHK("cclk_oe", 1'b0, cclk_oe)
		`CHK("lane_oe", 2'h2, lane_oe)
		`CHK("ss_oe", 1'b0, ss_oe)
		w0 = $random(seed);
		w1 = $random(seed);
		cfg_host_model_i.send_word(w0);
		cfg_host_model_i.send_word(w1);
		step(20);
		`CHK("stream_valid", 1'b1, stream_valid)
		`CHK("lane_copy", ~w1[0], lane_o[1])
		get_word(w0);
		get_word(w1);
		done_hold = 1'b1;
		load_done = 1'b1;
		step(10);
		`CHK("done_oe", 1'b0, done_oe)
		`CHK("done_o", 1'b0, done_o)
		`CHK("user", 1'b0, user)
		done_hold = 1'b0;
		step(10);
		load_done = 1'b0;
		`CHK("user", 1'b1, user)
		`CHK("cso", 1'b1, chip_select_out)
		`CHK("dual", 1'b1, dual)
		csi = 1'b0;
		req(1'b0);
		step(10);
		`CHK("user", 1'b1, user)
		csi = 1'b1;
		for (int k = 0; k < 3; k++) begin
			req(1'b0);
			step(10);
			{upd_fail, crc_fail, id_mis} = 3'h1 << k;
			step(1);
			{upd_fail, crc_fail, id_mis} = 3'h0;
			step(3);
			`CHK("error_n", 1'b0, error_n)
		end
		req(1'b0);
		step(10);
		`CHK("error_n", 1'b1, error_n)
		fork
			req(1'b1);
			for (int i = 31; i >= 0; i--) begin
				@(posedge cclk_o);
				cmd[i] = lane_o[0];
			end
		join
		`CHK("spi_cmd", SPI_READ_CMD, cmd)
		`CHK("cclk_oe", 1'b1, cclk_oe)
		`CHK("ss_oe", 1'b1, ss_oe)
		`CHK("ss_o", 1'b0, ss_o)
		`CHK("active", 1'b1, straps.active)
		cfg_host_model_i.tap_reset();
		jmove(8'h02, 4, oe);
		jshift(32, 32'h0000_0000, d, oe);
		`CHK("idcode", ID_TB, d)
		`CHK("tdo_oe_shift", 1'b1, oe)
		jmove(8'h01, 1, oe);
		`CHK("tdo_oe_idle", 1'b0, oe)
		jmove(8'h06, 5, oe);
		jshift(4, {28'h0, IR_BYPASS}, d, oe);
		`CHK("ir_capture", {28'h0, IR_CAPTURE}, d)
		jmove(8'h03, 4, oe);
		pat = 8'($random(seed));
		jshift(9, {24'h0, pat}, d, oe);
		`CHK("bypass", {pat, 1'b0}, d[8:0])
		jmove(8'h01, 2, oe);
		print_verdict();
	end
endmodule
